// ==== hw/wakeup_counter_status_top.sv ====
// Periodic wakeup unit with status readout, flags and modes.
// Assumes one 25 MHz clock, an AHB-Lite master and a count tick from logic.
//
// Contract
// RULE1: Bit 7 selects status source: 0 wakeup counter, 1 reset counter.
// RULE2: Select bit cleared only by non-stop-exit power-on reset.
// RULE3: Status bit 6 always reads zero.
// RULE4: Bits 5:0 read-only, show selected counter value.
// RULE5: Selected counter captured into status when status is read.
// RULE6: Counter reads zero right after its flag is generated.
// RULE7: Status field follows reset effect on selected counter.
// RULE8: Run mode wakeup sets wakeup flag and requests wakeup vector.
// RULE9: Software clears wakeup flag by writing one to its ack.
// RULE10: Run mode periodic reset sets flag and requests reset.
// RULE11: Software clears reset flag by writing one to its ack.
// RULE12: Registers keep programmed values after interrupt or reset; rst_n reloads both intervals to 6'h3F and the mask to 0.
// RULE13: Light stop events restart clocks and set flags.
// RULE14: Deep stop wakeup exits as power-on; interrupt stays pending.
// RULE15: Deep stop periodic reset exits power-on style, sets flag.
// RULE16: Deep stop exit keeps all unit registers.
// RULE17: Debug freezes unit and both counters; a pending deep stop wakeup still fires on int_unmasked.
// RULE18: Counting resumes once debug ends.
// RULE19: Status writes change only the select bit.
`include "wakeup_counter_status_map.svh"
module wakeup_counter_status_top
    import wakeup_counter_status_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        por_n,
    input  wire logic        stop_exit,
    input  wire logic        tick,
    input  wire logic        dbg_active,
    input  wire wakeup_counter_status_mode_t  mode,
    input  wire logic        int_unmasked,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq,
    output logic             wake_irq,
    output logic             periodic_reset,
    output logic             clk_restart
);
    wakeup_counter_status_state_t s_q;
    wakeup_counter_status_state_t s_d;
    logic        wr;
    logic        rd;
    logic        wake_evt;
    logic        reset_interval_counter_evt;
    logic        fz;
    logic        real_por;
    logic [5:0]  sel_cnt;

    // ----------------------------------------------------------------
    // Bus phase and events
    // ----------------------------------------------------------------
    always_comb begin
        wr  = s_q.hsel & s_q.hwr;
        rd  = hsel & htrans[1] & hready & ~hwrite &
              (haddr[11:0] == `WAKEUP_COUNTER_STATUS_OFF_STATUS);
        fz  = s_q.dbg_s2;                                       // RULE17
        // Power-on that is not a stop exit, caught two clocks after it asserts
        real_por = s_q.por_s2 & ~s_q.seen;
        wake_evt = tick & ~fz & (s_q.wut_ivl != '0) &
                   (s_q.wut_cnt + 6'h01 >= s_q.wut_ivl);        // RULE18
        reset_interval_counter_evt = wake_evt & (s_q.reset_interval_counter_ivl != '0) &
                   (s_q.reset_interval_counter_cnt + 6'h01 >= s_q.reset_interval_counter_ivl);
        sel_cnt  = s_q.psel ? s_q.reset_interval_counter_cnt : s_q.wut_cnt;       // RULE1 RULE4
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d        = s_q;
        s_d.dbg_s1 = dbg_active;
        s_d.dbg_s2 = s_q.dbg_s1;
        s_d.por_s1 = ~por_n & ~stop_exit;
        s_d.por_s2 = s_q.por_s1;
        s_d.seen   = s_q.por_s2;
        s_d.hsel   = hsel & htrans[1] & hready;
        s_d.hwr    = hwrite;
        s_d.haddr  = haddr[11:0];
        // Counters hold in debug; an event returns them to zero
        if (tick && !fz) begin
            s_d.wut_cnt = wake_evt ? 6'h00 : s_q.wut_cnt + 6'h01; // RULE6
            if (wake_evt) begin
                s_d.reset_interval_counter_cnt = reset_interval_counter_evt ? 6'h00
                                        : s_q.reset_interval_counter_cnt + 6'h01;
            end
        end
        if (rd) begin
            s_d.snap = sel_cnt;                                 // RULE5
        end
        // Hardware set wins over software clear
        if (wr && s_q.haddr == `WAKEUP_COUNTER_STATUS_OFF_STATUS) begin
            s_d.psel = hwdata[`WAKEUP_COUNTER_STATUS_BIT_PSEL];                  // RULE19
        end
        if (wr && s_q.haddr == `WAKEUP_COUNTER_STATUS_OFF_INTV) begin
            if (hwdata[5:0] != s_q.wut_ivl &&
                !(hwdata[5:0] == '0 && s_q.reset_interval_counter_ivl == '0)) begin
                s_d.wut_ivl = hwdata[5:0];
                s_d.wut_cnt = 6'h00;
            end
            if (hwdata[13:8] != s_q.reset_interval_counter_ivl &&
                !(hwdata[13:8] == '0 && s_q.wut_ivl == '0)) begin
                s_d.reset_interval_counter_ivl = hwdata[13:8];
                s_d.reset_interval_counter_cnt = 6'h00;
            end
        end
        if (wr && s_q.haddr == `WAKEUP_COUNTER_STATUS_OFF_EVT) begin
            if (hwdata[`WAKEUP_COUNTER_STATUS_BIT_WUF]) s_d.wakeup_flag = 1'b0;          // RULE9
            if (hwdata[`WAKEUP_COUNTER_STATUS_BIT_PRF]) s_d.periodic_reset_flag = 1'b0;          // RULE11
        end
        if (wr && s_q.haddr == `WAKEUP_COUNTER_STATUS_OFF_MASK) begin
            s_d.mask = hwdata[1:0];
        end
        if (wake_evt) s_d.wakeup_flag = 1'b1;                           // RULE8
        if (reset_interval_counter_evt) s_d.periodic_reset_flag = 1'b1;                           // RULE10
        // Deep stop keeps the wakeup pending until unmasked
        if (wake_evt && mode == WAKEUP_COUNTER_STATUS_DEEP) begin
            s_d.pending = 1'b1;                                 // RULE14
        end else if (int_unmasked) begin
            s_d.pending = 1'b0;
        end
        s_d.wake_irq = (wake_evt && mode != WAKEUP_COUNTER_STATUS_DEEP) ||
                       (s_q.pending && int_unmasked);           // RULE14
        s_d.preset = reset_interval_counter_evt | (wake_evt & mode == WAKEUP_COUNTER_STATUS_DEEP); // RULE15
        s_d.clk_restart = (wake_evt | reset_interval_counter_evt) &
                          (mode == WAKEUP_COUNTER_STATUS_LIGHT);                 // RULE13
        // Power-on clears only select and reset flag; others kept
        if (real_por) begin
            s_d.psel = 1'b0;                                    // RULE2
            s_d.periodic_reset_flag  = 1'b0;                                    // RULE16
        end
        s_d.irq = |({s_d.periodic_reset_flag, s_d.wakeup_flag} & s_d.mask);
        s_d.rdata = 32'h0000_0000;
        unique case (haddr[11:0])
            `WAKEUP_COUNTER_STATUS_OFF_STATUS: s_d.rdata[7:0] =
                {s_q.psel, 1'b0, sel_cnt};                      // RULE3 RULE7
            `WAKEUP_COUNTER_STATUS_OFF_CTRL:   s_d.rdata[7:0] = {s_q.psel, 7'h00};
            `WAKEUP_COUNTER_STATUS_OFF_EVT:    s_d.rdata[1:0] = {s_q.periodic_reset_flag, s_q.wakeup_flag};
            `WAKEUP_COUNTER_STATUS_OFF_MASK:   s_d.rdata[1:0] = s_q.mask;
            `WAKEUP_COUNTER_STATUS_OFF_INTV:   s_d.rdata[13:0] =
                {s_q.reset_interval_counter_ivl, 2'b00, s_q.wut_ivl};
            default:          s_d.rdata = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------------------------------
    // State register; reset reloads intervals and mask, keeps select and reset flag
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin                // RULE12
        if (!rst_n) begin
            // Select and reset flag ride through; of the resets only power-on clears them
            s_q.wut_cnt     <= 6'h00;
            s_q.reset_interval_counter_cnt    <= 6'h00;
            s_q.wut_ivl     <= `WAKEUP_COUNTER_STATUS_RST_CNT;
            s_q.reset_interval_counter_ivl    <= `WAKEUP_COUNTER_STATUS_RST_CNT;
            s_q.snap        <= 6'h00;
            s_q.wakeup_flag         <= 1'b0;
            s_q.mask        <= `WAKEUP_COUNTER_STATUS_RST_MASK;
            s_q.hsel        <= 1'b0;
            s_q.hwr         <= 1'b0;
            s_q.haddr       <= 12'h000;
            s_q.rdata       <= 32'h0000_0000;
            s_q.irq         <= 1'b0;
            s_q.wake_irq    <= 1'b0;
            s_q.preset      <= 1'b0;
            s_q.clk_restart <= 1'b0;
            s_q.pending     <= 1'b0;
            s_q.dbg_s1      <= 1'b0;
            s_q.dbg_s2      <= 1'b0;
            s_q.por_s1      <= 1'b0;
            s_q.por_s2      <= 1'b0;
            s_q.seen        <= 1'b1;                             // RULE2
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata         = s_q.rdata;
    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
    assign irq            = s_q.irq;
    assign wake_irq       = s_q.wake_irq;
    assign periodic_reset = s_q.preset;
    assign clk_restart    = s_q.clk_restart;
endmodule

// ==== inc/wakeup_counter_status_map.svh ====
// Register offsets, field positions and reset values of the wakeup unit.
// Assumes inclusion by the package and the top module.
`ifndef WAKEUP_COUNTER_STATUS_MAP_SVH
`define WAKEUP_COUNTER_STATUS_MAP_SVH
// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define WAKEUP_COUNTER_STATUS_OFF_STATUS   12'h000
`define WAKEUP_COUNTER_STATUS_OFF_CTRL     12'h004
`define WAKEUP_COUNTER_STATUS_OFF_EVT      12'h008
`define WAKEUP_COUNTER_STATUS_OFF_MASK     12'h00C
`define WAKEUP_COUNTER_STATUS_OFF_INTV     12'h010
// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define WAKEUP_COUNTER_STATUS_BIT_PSEL     7
`define WAKEUP_COUNTER_STATUS_BIT_WUF      0
`define WAKEUP_COUNTER_STATUS_BIT_PRF      1
`define WAKEUP_COUNTER_STATUS_CNT_W        6
`define WAKEUP_COUNTER_STATUS_RST_CNT      6'h3F
`define WAKEUP_COUNTER_STATUS_RST_MASK     2'h0
`endif

// ==== inc/wakeup_counter_status_pkg.sv ====
// Types of the wakeup unit.
// Assumes wakeup_counter_status_map.svh on the include path.
`include "wakeup_counter_status_map.svh"
package wakeup_counter_status_pkg;
    typedef enum logic [1:0] {
        WAKEUP_COUNTER_STATUS_RUN   = 2'h0,
        WAKEUP_COUNTER_STATUS_LIGHT = 2'h1,
        WAKEUP_COUNTER_STATUS_DEEP  = 2'h3
    } wakeup_counter_status_mode_t;

    typedef struct packed {
        logic       psel;
        logic [5:0] wut_cnt;
        logic [5:0] reset_interval_counter_cnt;
        logic [5:0] wut_ivl;
        logic [5:0] reset_interval_counter_ivl;
        logic [5:0] snap;
        logic       wakeup_flag;
        logic       periodic_reset_flag;
        logic [1:0] mask;
        logic       hsel;
        logic       hwr;
        logic [11:0] haddr;
        logic [31:0] rdata;
        logic       irq;
        logic       wake_irq;
        logic       preset;
        logic       clk_restart;
        logic       pending;
        logic       dbg_s1;
        logic       dbg_s2;
        logic       por_s1;
        logic       por_s2;
        logic       seen;
    } wakeup_counter_status_state_t;
endpackage

// ==== verif/tb.sv ====
// Self-checking bench for the wakeup unit.
// Assumes wakeup_counter_status_core as timebase and the bound checker.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import wakeup_counter_status_pkg::*;
    logic clk, rst_n, por_n, stop_exit, tick, dbg, unm, hsel, hwrite, load;
    logic hrdy, irq, wk, prs, cr, hresp;
    wakeup_counter_status_mode_t  mode;
    logic [1:0]  htrans;
    logic [5:0]  n;
    logic [31:0] haddr, hwdata, hrdata, r;
    int mismatches, checks;
    int n_wk, n_prs, n_cr;
    localparam logic [44:0] ROWS [9] = '{{1'b0, 12'h000, 32'h0}, {1'b0, 12'h008,
        32'h0}, {1'b0, 12'h020, 32'h0}, {1'b1, 12'h000, 32'h7F}, {1'b0, 12'h000,
        32'h0}, {1'b1, 12'h000, 32'h80}, {1'b0, 12'h000, 32'h80}, {1'b1, 12'h00C,
        32'h3}, {1'b0, 12'h00C, 32'h3}};
    wakeup_counter_status_core u_core (.clk(clk), .rst_n(rst_n), .load(load), .n(n), .tick(tick));
    wakeup_counter_status_top u_dut (.clk(clk), .rst_n(rst_n), .por_n(por_n), .stop_exit(stop_exit),
        .tick(tick), .dbg_active(dbg), .mode(mode), .int_unmasked(unm), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy),
        .hresp(hresp), .irq(irq), .wake_irq(wk), .periodic_reset(prs),
        .clk_restart(cr));
    // Pulses toward the core, counted for the closing checks
    always @(posedge clk) begin
        n_wk  <= n_wk + ((wk === 1'b1) ? 1 : 0);
        n_prs <= n_prs + ((prs === 1'b1) ? 1 : 0);
        n_cr  <= n_cr + ((cr === 1'b1) ? 1 : 0);
    end
    task end_sim;
        if (mismatches == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", s, exp, seen);
        end
    endtask
    // ----------------------------------------------------------------
    // Bus and timebase helpers
    // ----------------------------------------------------------------
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 20'h0, a};
        do @(posedge clk); while (hrdy !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
        do @(posedge clk); while (hrdy !== 1'b1);
        r = hrdata;
    endtask
    task fire(input logic [5:0] k);
        @(posedge clk);
        {load, n} <= {1'b1, k};
        @(posedge clk);
        load <= 1'b0;
        repeat (k + 8) @(posedge clk);
    endtask
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    initial begin
        #400000;
        mismatches++;
        end_sim();
    end
    initial begin
        {rst_n, por_n, stop_exit, dbg, unm, hsel, hwrite, load, htrans} = '0;
        {haddr, hwdata, n} = '0;
        mode = WAKEUP_COUNTER_STATUS_RUN;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        // Power-on outlasts the bus reset so select and flag start known
        repeat (4) @(posedge clk);
        por_n <= 1'b1;
        foreach (ROWS[i]) begin
            bus(ROWS[i][44], ROWS[i][43:32], ROWS[i][31:0]);
            if (!ROWS[i][44]) chk("row", r, ROWS[i][31:0]);
        end
        rst_n <= 1'b0;
        @(posedge clk) rst_n <= 1'b1;
        bus(0, 12'h000, 0); chk("bus reset", r, 32'h80);
        {por_n, stop_exit} <= 2'b01; repeat (6) @(posedge clk); por_n <= 1'b1;
        bus(0, 12'h000, 0); chk("stop exit", r, 32'h80);
        {por_n, stop_exit} <= 2'b00; repeat (6) @(posedge clk); por_n <= 1'b1;
        bus(0, 12'h000, 0); chk("power on", r, 32'h0);
        fire(5); bus(0, 12'h000, 0); chk("count", r, 32'h5);
        dbg <= 1'b1; fire(3); bus(0, 12'h000, 0); chk("freeze", r, 32'h5);
        dbg <= 1'b0; fire(1); bus(0, 12'h000, 0); chk("resume", r, 32'h6);
        bus(1, 12'h010, 32'h3F02); bus(1, 12'h00C, 32'h3);
        for (int i = 0; i < 3; i++) begin
            mode <= (i == 0) ? WAKEUP_COUNTER_STATUS_RUN : (i == 1) ? WAKEUP_COUNTER_STATUS_LIGHT : WAKEUP_COUNTER_STATUS_DEEP;
            unm <= (i != 2);
            fire(2); unm <= 1'b1;
            bus(0, 12'h000, 0); chk("after flag", r, 32'h0);
            bus(0, 12'h008, 0); chk("wake flag", r[0], 1);
            chk("irq set", irq, 1);
            bus(1, 12'h008, 32'h1); bus(0, 12'h008, 0);
            chk("wake ack", {r[0], irq}, 0);
        end
        bus(0, 12'h010, 0); chk("kept", r[13:0], 14'h3F02);
        mode <= WAKEUP_COUNTER_STATUS_RUN;
        bus(1, 12'h010, 32'h0102); fire(2);
        bus(0, 12'h008, 0); chk("reset flag", r[1], 1);
        bus(1, 12'h008, 32'h3); bus(0, 12'h008, 0);
        chk("reset ack", r[1:0], 0);
        chk("wake pulses", n_wk, 4);
        chk("reset pulses", n_prs, 2);
        chk("restart pulses", n_cr, 1);
        end_sim();
    end
endmodule

// ==== verif/wakeup_counter_status_chk.sv ====
// Port assertions for the wakeup unit.
// Assumes the bind at the foot onto wakeup_counter_status_top.
module wakeup_counter_status_chk
    import wakeup_counter_status_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        dbg_active,
    input wire wakeup_counter_status_mode_t  mode,
    input wire logic        int_unmasked,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        irq,
    input wire logic        wake_irq,
    input wire logic        periodic_reset,
    input wire logic        clk_restart
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic rd;
    assign rd = hsel && htrans[1] && !hwrite && hready;
    a_zero_wait: assert property (hreadyout && !hresp)
        else $error("slave stalled or erred");
    a_unused_zero: assert property (rd && haddr == 32'h0000_0000
        |=> hrdata[31:6] == 26'h0 || hrdata[31:6] == 26'h2)
        else $error("status upper bits wrong");
    a_unmapped_zero: assert property (rd && haddr == 32'h0000_0020
        |=> hrdata == 32'h0000_0000) else $error("unmapped read nonzero");
    a_frozen_quiet: assert property (dbg_active [*4]
        |-> !wake_irq && !periodic_reset) else $error("event while frozen");
    a_wake_pulse: assert property (wake_irq |=> !wake_irq)
        else $error("wake_irq longer than a cycle");
    a_reset_pulse: assert property (periodic_reset |=> !periodic_reset)
        else $error("periodic_reset longer than a cycle");
    a_deep_pend: assert property ((mode == WAKEUP_COUNTER_STATUS_DEEP && !int_unmasked) [*2]
        |-> !wake_irq) else $error("wake vector while masked");
    a_restart_light: assert property (clk_restart
        |-> $past(mode) == WAKEUP_COUNTER_STATUS_LIGHT) else $error("restart outside light");
    c_wake: cover property (wake_irq);
    c_preset: cover property (periodic_reset);
    c_irq: cover property ($rose(irq));
endmodule
bind wakeup_counter_status_top wakeup_counter_status_chk u_chk (.clk(clk), .rst_n(rst_n),
    .dbg_active(dbg_active),
    .mode(mode), .int_unmasked(int_unmasked), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .wake_irq(wake_irq),
    .periodic_reset(periodic_reset), .clk_restart(clk_restart));

// ==== verif/wakeup_counter_status_core.sv ====
// Timebase side model: issues an exact burst of count ticks.
// Assumes the unit clock; load is one cycle wide.
module wakeup_counter_status_core (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       load,
    input  wire logic [5:0] n,
    output logic            tick
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] cnt_q;
    // Back-to-back ticks, the hardest spacing the unit must take
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) cnt_q <= 6'h00;
        else if (load) cnt_q <= n;
        else if (cnt_q != 6'h00) cnt_q <= cnt_q - 6'h01;
    end
    assign tick = (cnt_q != 6'h00);
endmodule
